// ### core/cmd_ctrl_pkg.sv
package cmd_ctrl_pkg;

   // register byte offsets in the operational space
   localparam logic [7:0] CAP_PARAMS_OFF = 8'h08;
   localparam logic [7:0] CMD_OFF        = 8'h20;
   localparam logic [7:0] STS_OFF        = 8'h24;

   // command register fields
   localparam int RUN_STOP_BIT   = 0;
   localparam int SOFT_RESET_BIT = 1;
   localparam int FL_SIZE_LSB    = 2;
   localparam int FL_SIZE_MSB    = 3;

   // status and capability fields
   localparam int HALTED_BIT     = 12;
   localparam int PROG_FL_BIT    = 1;

   // frame list size codes
   localparam logic [1:0] FL_SIZE_1024  = 2'h0;
   localparam logic [1:0] FL_SIZE_512   = 2'h1;
   localparam logic [1:0] FL_SIZE_256   = 2'h2;
   localparam logic [1:0] FL_SIZE_RESET = FL_SIZE_1024;

   // reset values
   localparam logic RUN_STOP_RESET = 1'b0;
   localparam logic HALTED_RESET   = 1'b1;

   // soft reset duration
   localparam int CLK_PERIOD_NS     = 25;
   localparam int SOFT_RESET_NS     = 400;
   localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_CNT_W         = 5;

   // run/stop sequencing
   typedef enum logic [1:0] {
      ST_HALTED    = 2'b00,
      ST_RUNNING   = 2'b01,
      ST_STOPPING  = 2'b10,
      ST_RESETTING = 2'b11
   } run_state_t;

endpackage

// ### core/reset_timer.sv
`timescale 1ns/1ps

module reset_timer #(
   parameter int CNT_W  = 5,
   parameter int CYCLES = 16
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control
   input  wire logic start,
   output logic      busy,
   output logic      done
);

   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

   logic [CNT_W-1:0] cnt_q;
   logic             busy_q;

   // a start while busy is ignored so the reset always runs its full length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= '0;
         busy_q <= 1'b0;
      end else if (busy_q) begin
         if (cnt_q == LAST) begin
            busy_q <= 1'b0;
            cnt_q  <= '0;
         end else begin
            cnt_q <= cnt_q + CNT_W'(1);
         end
      end else if (start) begin
         busy_q <= 1'b1;
         cnt_q  <= '0;
      end
   end

   assign busy = busy_q;
   assign done = busy_q && (cnt_q == LAST);

endmodule

// ### core/host_cmd_run_reset_ctrl.sv
`timescale 1ns/1ps

module host_cmd_run_reset_ctrl
   import cmd_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // capability and controller status
   input  wire logic        programmable_frame_list_cap,
   input  wire logic        pipeline_idle,
   input  wire logic [13:0] frame_index,
   // controller control
   output logic             schedule_run,
   output logic             core_soft_reset,
   output logic             transaction_abort,
   output logic             port_owner_release,
   output logic             usb_bus_reset,
   output logic [9:0]       frame_list_index,
   output logic [1:0]       frame_list_size,
   output logic             halted_flag
);

   run_state_t  state_q;
   run_state_t  state_d;
   logic [1:0]  size_q;
   logic        run_stop_q;
   logic        halted_q;
   logic        rst_busy;
   logic        rst_done;
   logic        rst_start;
   logic [9:0]  index_q;
   logic [31:0] rdata_q;
   logic        setup;
   logic        access;
   logic        wr_cmd;
   logic        mapped;

   // apb phases and decode
   assign setup  = psel && !penable;
   assign access = psel && penable;
   assign mapped = (paddr == CMD_OFF) || (paddr == STS_OFF) || (paddr == CAP_PARAMS_OFF);
   assign wr_cmd = access && pwrite && (paddr == CMD_OFF);

   // zero wait state slave; error flagged only on unmapped offsets
   assign pready  = access;
   assign pslverr = access && !mapped;
   assign prdata  = rdata_q;

   // a one written while idle starts the timed reset sequence
   assign rst_start = wr_cmd && pwdata[SOFT_RESET_BIT] && !rst_busy;

   reset_timer #(
      .CNT_W  (RST_CNT_W),
      .CYCLES (SOFT_RESET_CYCLES)
   ) u_reset_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (rst_start),
      .busy    (rst_busy),
      .done    (rst_done)
   );

   // frame list size; locked while reset runs, restored by it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         size_q <= FL_SIZE_RESET;
      end else if (rst_busy) begin
         size_q <= FL_SIZE_RESET;
      end else if (wr_cmd && programmable_frame_list_cap && !pwdata[SOFT_RESET_BIT]) begin
         size_q <= pwdata[FL_SIZE_MSB:FL_SIZE_LSB];
      end
   end

   // run/stop bit; a reset write clears it together with the rest
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_stop_q <= RUN_STOP_RESET;
      end else if (rst_busy || rst_start) begin
         run_stop_q <= RUN_STOP_RESET;
      end else if (wr_cmd) begin
         run_stop_q <= pwdata[RUN_STOP_BIT];
      end
   end

   // schedule sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_HALTED: begin
            if (run_stop_q) begin
               state_d = ST_RUNNING;
            end
         end
         ST_RUNNING: begin
            if (!run_stop_q) begin
               state_d = ST_STOPPING;
            end
         end
         ST_STOPPING: begin
            // a set again before the pipeline drains resumes running
            if (run_stop_q) begin
               state_d = ST_RUNNING;
            end else if (pipeline_idle) begin
               state_d = ST_HALTED;
            end
         end
         ST_RESETTING: begin
            if (rst_done) begin
               state_d = ST_HALTED;
            end
         end
         default: begin
            state_d = ST_HALTED;
         end
      endcase
      if (rst_start) begin
         state_d = ST_RESETTING;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_HALTED;
      end else begin
         state_q <= state_d;
      end
   end

   // halted flag follows entry to and exit from the halted and resetting states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halted_q <= HALTED_RESET;
      end else begin
         halted_q <= (state_d == ST_HALTED) || (state_d == ST_RESETTING);
      end
   end

   // current index into the frame list, chosen by the size field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         index_q <= '0;
      end else begin
         case (size_q)
            FL_SIZE_1024: index_q <= frame_index[12:3];
            FL_SIZE_512:  index_q <= {1'b0, frame_index[11:3]};
            FL_SIZE_256:  index_q <= {2'b00, frame_index[10:3]};
            default:  index_q <= frame_index[12:3];
         endcase
      end
   end

   // read data captured in the setup phase, valid through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= '0;
      end else if (setup && !pwrite) begin
         rdata_q <= '0;
         case (paddr)
            CMD_OFF: begin
               rdata_q[RUN_STOP_BIT]    <= run_stop_q;
               rdata_q[SOFT_RESET_BIT]  <= rst_busy;
               rdata_q[FL_SIZE_MSB:FL_SIZE_LSB] <= size_q;
            end
            STS_OFF: begin
               rdata_q[HALTED_BIT] <= halted_q;
            end
            CAP_PARAMS_OFF: begin
               rdata_q[PROG_FL_BIT] <= programmable_frame_list_cap;
            end
            default: begin
               rdata_q <= '0;
            end
         endcase
      end
   end

   // controller-facing controls; configuration space is outside this block
   assign schedule_run       = (state_q == ST_RUNNING) || (state_q == ST_STOPPING);
   assign core_soft_reset    = rst_busy;
   assign transaction_abort  = rst_start || rst_busy;
   assign port_owner_release = rst_busy;
   assign usb_bus_reset      = 1'b0;
   assign frame_list_index   = index_q;
   assign frame_list_size    = size_q;
   assign halted_flag        = halted_q;

   // ---------------- assertions ----------------
   localparam int RST_MAX = SOFT_RESET_CYCLES + 2;
   localparam int RST_LEN = SOFT_RESET_CYCLES;

   size_reset_val_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(rst_busy) |-> (size_q == FL_SIZE_RESET))
      else $error("size field not restored by soft reset");

   size_locked_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cmd && !programmable_frame_list_cap) |=> $stable(size_q))
      else $error("size field changed without capability");

   size_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cmd && programmable_frame_list_cap && !rst_busy && !pwdata[SOFT_RESET_BIT])
      |=> (size_q == $past(pwdata[FL_SIZE_MSB:FL_SIZE_LSB])))
      else $error("size field write lost");

   index_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      (size_q == FL_SIZE_256) && $stable(size_q) |=> (frame_list_index[9:8] == 2'b00))
      else $error("index wider than selected size");

   abort_now_a: assert property (@(posedge pclk) disable iff (!presetn)
      rst_start |-> transaction_abort ##1 (core_soft_reset && transaction_abort))
      else $error("reset did not abort at once");

   no_bus_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      !usb_bus_reset)
      else $error("bus reset driven");

   owner_release_a: assert property (@(posedge pclk) disable iff (!presetn)
      rst_start |=> port_owner_release && !schedule_run && !run_stop_q)
      else $error("ports or run state not reset");

   self_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      rst_start |=> rst_busy [*4] ##[1:RST_MAX] !rst_busy)
      else $error("soft reset did not self clear in time");

   // the reset runs its full length, no shorter and no longer
   reset_length_a: assert property (@(posedge pclk) disable iff (!presetn)
      rst_start |-> ##RST_LEN rst_busy ##1 !rst_busy)
      else $error("soft reset length wrong");

   zero_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rst_busy && !rst_done && wr_cmd && !pwdata[SOFT_RESET_BIT]) |=> rst_busy)
      else $error("zero write cut reset short");

   run_exec_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_RUNNING && run_stop_q) |-> schedule_run && !halted_flag)
      else $error("running without schedule");

   drain_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_STOPPING && !pipeline_idle) |=> !halted_flag)
      else $error("halted before pipeline drained");

   halt_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_STOPPING && pipeline_idle && !run_stop_q && !rst_start)
      |=> halted_flag && !schedule_run)
      else $error("halted flag missing after stop");

endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
   import cmd_ctrl_pkg::*;

   // clock, reset and bus
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] prdata;
   // controller side
   logic        cap;
   logic        pipeline_idle;
   logic [13:0] frame_index;
   logic        schedule_run;
   logic        core_soft_reset;
   logic        transaction_abort;
   logic        port_owner_release;
   logic        usb_bus_reset;
   logic [9:0]  frame_list_index;
   logic [1:0]  frame_list_size;
   logic        halted_flag;
   // bookkeeping
   int          bad_count;
   int          num_checks;
   int          cyc;
   logic [9:0]  exp_idx [4];

   host_cmd_run_reset_ctrl host_cmd_run_reset_ctrl_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .programmable_frame_list_cap(cap),
      .pipeline_idle(pipeline_idle), .frame_index(frame_index),
      .schedule_run(schedule_run), .core_soft_reset(core_soft_reset),
      .transaction_abort(transaction_abort), .port_owner_release(port_owner_release),
      .usb_bus_reset(usb_bus_reset), .frame_list_index(frame_list_index),
      .frame_list_size(frame_list_size), .halted_flag(halted_flag));

   // 40 MHz clock
   initial pclk = 1'b0;
   always #12.5 pclk = ~pclk;

   // hang guard, well above the 150 or so cycles the sequence needs
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count = bad_count + 1;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
         bad_count = bad_count + 1;
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait-state count assumed; only the hang guard ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, addr, wd, rd, err);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] mask,
                         input logic [31:0] exp, input logic exp_err);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, addr, 32'h0000_0000, rd, err);
      check(name, exp, rd & mask);
      check({name, " error"}, {31'h0, exp_err}, {31'h0, err});
   endtask

   // lets the edge updates land before outputs are looked at
   task automatic cycles(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   // main sequence
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; cap = 1'b0; pipeline_idle = 1'b1;
      frame_index = 14'h3ABC; bad_count = 0; num_checks = 0; cyc = 0;
      // bits 12 and 11 set so that each defined size code yields a different index; reserved code 3 matches code 0
      exp_idx[0] = 10'h357;
      exp_idx[1] = 10'h157;
      exp_idx[2] = 10'h057;
      exp_idx[3] = 10'h357;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // reset values and the capability word
      rd_chk("cmd reset", CMD_OFF, 32'h0000_000F, 32'h0000_0000, 1'b0);
      rd_chk("halted reset", STS_OFF, 32'h0000_1000, 32'h0000_1000, 1'b0);
      rd_chk("cap clear", CAP_PARAMS_OFF, 32'h0000_0002, 32'h0000_0000, 1'b0);
      rd_chk("unmapped", 8'h44, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
      // size field locked without the capability
      wr(CMD_OFF, 32'h0000_0004);
      cycles(2);
      check("locked size", {30'h0, FL_SIZE_RESET}, {30'h0, frame_list_size});
      @(posedge pclk);
      cap <= 1'b1;
      rd_chk("cap set", CAP_PARAMS_OFF, 32'h0000_0002, 32'h0000_0002, 1'b0);
      // every size code, reserved one too, with the index bits it selects
      for (int c = 3; c >= 0; c--) begin
         wr(CMD_OFF, 32'(c) << FL_SIZE_LSB);
         cycles(3);
         check("size", 32'(c), {30'h0, frame_list_size});
         check("index", {22'h0, exp_idx[c]}, {22'h0, frame_list_index});
      end
      // run with a busy pipeline, then stop and drain
      rd_chk("halted before run", STS_OFF, 32'h0000_1000, 32'h0000_1000, 1'b0);
      @(posedge pclk);
      pipeline_idle <= 1'b0;
      wr(CMD_OFF, 32'h0000_0001);
      cycles(3);
      check("running", 32'h1, {31'h0, schedule_run});
      rd_chk("halted while run", STS_OFF, 32'h0000_1000, 32'h0000_0000, 1'b0);
      wr(CMD_OFF, 32'h0000_0000);
      cycles(6);
      check("draining", 32'h1, {31'h0, schedule_run});
      check("not yet halted", 32'h0, {31'h0, halted_flag});
      @(posedge pclk);
      pipeline_idle <= 1'b1;
      cycles(3);
      check("halted", 32'h1, {31'h0, halted_flag});
      check("stopped", 32'h0, {31'h0, schedule_run});
      // soft reset from halted, size preset to 512
      wr(CMD_OFF, 32'h0000_0004);
      wr(CMD_OFF, 32'h0000_0002);
      cycles(1);
      check("core reset", 32'h1, {31'h0, core_soft_reset});
      check("abort", 32'h1, {31'h0, transaction_abort});
      check("no bus reset", 32'h0, {31'h0, usb_bus_reset});
      check("ports released", 32'h1, {31'h0, port_owner_release});
      wr(CMD_OFF, 32'h0000_0000);
      rd_chk("reset holds", CMD_OFF, 32'h0000_0002, 32'h0000_0002, 1'b0);
      cycles(SOFT_RESET_CYCLES + 4);
      rd_chk("reset done", CMD_OFF, 32'h0000_000F, 32'h0000_0000, 1'b0);
      check("size restored", {30'h0, FL_SIZE_RESET}, {30'h0, frame_list_size});
      check("reset ended", 32'h0, {31'h0, core_soft_reset});
      check("abort ended", 32'h0, {31'h0, transaction_abort});
      rd_chk("halted after", STS_OFF, 32'h0000_1000, 32'h0000_1000, 1'b0);
      // software sets the controller up again
      wr(CMD_OFF, 32'h0000_0008);
      cycles(2);
      check("reinit size", {30'h0, FL_SIZE_256}, {30'h0, frame_list_size});
      // reset requested while running, once halted reads 0
      wr(CMD_OFF, 32'h0000_0009);
      cycles(2);
      rd_chk("halted clear", STS_OFF, 32'h0000_1000, 32'h0000_0000, 1'b0);
      wr(CMD_OFF, 32'h0000_0002);
      cycles(1);
      check("run abort", 32'h1, {31'h0, transaction_abort});
      check("run reset stop", 32'h0, {31'h0, schedule_run});
      cycles(SOFT_RESET_CYCLES + 4);
      check("run reset size", {30'h0, FL_SIZE_RESET}, {30'h0, frame_list_size});
      check("run reset halted", 32'h1, {31'h0, halted_flag});
      check("run reset ended", 32'h0, {31'h0, core_soft_reset});
      complete_run();
   end

endmodule
